// *** inc/cmdc_consts.svh ***
`ifndef CMDC_CONSTS_SVH
`define CMDC_CONSTS_SVH
`define CMDC_REG_INDEX        8'h05
`define CMDC_REG_ADDR         12'h014
`define CMDC_REG_RESET        24'he00000
`define CMDC_WRITE_MASK       24'he073ff
`define CMDC_LA_CM_BIT        23
`define CMDC_LL_CM_BIT        22
`define CMDC_RA_CM_BIT        21
`define CMDC_LA_SUM_BIT       14
`define CMDC_LL_SUM_BIT       13
`define CMDC_RA_SUM_BIT       12
`define CMDC_CE_SUM_BIT       9
`define CMDC_CE_REF_BIT       8
`define CMDC_REFSEL_HI        7
`define CMDC_REFSEL_LO        4
`define CMDC_DRIVE_OUT_BIT    3
`define CMDC_EXT_SRC_BIT      2
`define CMDC_REF_EN_BIT       1
`define CMDC_SHIELD_BIT       0
`define CMDC_SEL_DRIVEN_LEAD  4'h0
`define CMDC_SEL_LA           4'h1
`define CMDC_SEL_LL           4'h2
`define CMDC_SEL_RA           4'h3
`define CMDC_RESP_OKAY        2'h0
`define CMDC_RESP_SLVERR      2'h2
`endif

// *** inc/cmdc_pkg.sv ***
package cmdc_pkg;
  typedef enum logic [1:0] {
    CMDC_CM_ELECTRODES,
    CMDC_CM_INTERNAL_REF,
    CMDC_CM_EXTERNAL
  } cmdc_cm_src_t;
endpackage : cmdc_pkg

// *** logic/cmdc_common_mode_drive_control.sv ***
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cmdc_consts.svh"
// Operation
// - Each electrode select bit set puts its electrode into the common-mode average.
// - The common mode is the average of the selected electrodes, or the single one alone.
// - With no electrode selected the common mode comes from the internal fixed reference.
// - The external-source bit opens all internal common-mode switches and overrides the selects.
// - The drive-out bit sends the internal common mode to its pin, but not under external source.
// - The three driven-lead summing bits each join their electrode to the summing input, reset zero.
// - The common-electrode summing bit adds the common electrode to the summing input.
// - The common-electrode reference enable turns on the common electrode, reset zero.
// - The reference-drive field picks driven lead, LA, LL or RA for codes 0 to 3, others reserved.
// - The reference-electrode enable turns on the right-leg-drive reference electrode.
// - The shield-drive enable turns on the shield driver.
// - The register sits at index 0x05 and resets to 0xe00000.
module cmdc_common_mode_drive_control (
  // Clock and reset
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  // AXI4-Lite write address and data
  input  wire logic [11:0]         s_axi_awaddr_i,
  input  wire logic                s_axi_awvalid_i,
  output logic                     s_axi_awready_o,
  input  wire logic [31:0]         s_axi_wdata_i,
  input  wire logic [3:0]          s_axi_wstrb_i,
  input  wire logic                s_axi_wvalid_i,
  output logic                     s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp_o,
  output logic                     s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [11:0]         s_axi_araddr_i,
  input  wire logic                s_axi_arvalid_i,
  output logic                     s_axi_arready_o,
  output logic [31:0]              s_axi_rdata_o,
  output logic [1:0]               s_axi_rresp_o,
  output logic                     s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i,
  // Common mode controls
  output cmdc_pkg::cmdc_cm_src_t   cm_src_o,
  output logic [2:0]               cm_switch_o,
  output logic                     cm_drive_out_o,
  // Driven lead and reference controls
  output logic [2:0]               drive_sum_o,
  output logic                     common_electrode_drive_sum_o,
  output logic                     common_electrode_ref_enable_o,
  output logic [3:0]               ref_electrode_o,
  output logic                     reference_electrode_enable_o,
  output logic                     shield_drive_enable_o
);
  typedef struct packed {
    logic [23:0] cfg;
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cmdc_state_t;

  cmdc_state_t st;
  cmdc_state_t next_st;
  logic [23:0] wr_merge;
  logic [23:0] wr_mask;
  logic [23:0] wr_data;
  logic [3:0]  wr_strb;

  // Write data may arrive now or may be held from an earlier cycle.
  assign wr_strb = st.w_held ? st.w_strb : s_axi_wstrb_i;
  assign wr_data = st.w_held ? st.w_data[23:0] : s_axi_wdata_i[23:0];

  // Lane 3 carries no field, so its strobe is ignored.
  for (genvar lane = 0; lane < 3; lane++) begin : g_lane_mask
    assign wr_mask[lane*8 +: 8] = {8{wr_strb[lane]}};
  end

  assign s_axi_awready_o = ~st.aw_held & ~st.bvalid;
  assign s_axi_wready_o  = ~st.w_held & ~st.bvalid;
  assign s_axi_arready_o = ~st.rvalid;

  always_comb begin
    next_st  = st;
    wr_merge = st.cfg;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata_i;
      next_st.w_strb = s_axi_wstrb_i;
    end
    if (next_st.aw_held && next_st.w_held) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      if (next_st.aw_addr[11:2] == {2'h0, `CMDC_REG_INDEX}) begin
        next_st.bresp = `CMDC_RESP_OKAY;
        wr_merge    = (st.cfg & ~wr_mask) | (wr_data & wr_mask);
        next_st.cfg = wr_merge & `CMDC_WRITE_MASK;
      end else begin
        next_st.bresp = `CMDC_RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready_i) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready_i) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_st.rvalid = 1'b1;
      if (s_axi_araddr_i[11:2] == {2'h0, `CMDC_REG_INDEX}) begin
        next_st.rdata = {8'h00, st.cfg};
        next_st.rresp = `CMDC_RESP_OKAY;
      end else begin
        next_st.rdata = 32'h00000000;
        next_st.rresp = `CMDC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st     <= '0;
      st.cfg <= `CMDC_REG_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_bvalid_o = st.bvalid;
  assign s_axi_bresp_o  = st.bresp;
  assign s_axi_rvalid_o = st.rvalid;
  assign s_axi_rdata_o  = st.rdata;
  assign s_axi_rresp_o  = st.rresp;

  cmdc_switch_decode u_decode (
    .cfg_i           (st.cfg),
    .cm_src_o        (cm_src_o),
    .cm_switch_o     (cm_switch_o),
    .cm_drive_pin_o  (cm_drive_out_o),
    .ref_electrode_o (ref_electrode_o)
  );

  assign drive_sum_o = {st.cfg[`CMDC_LA_SUM_BIT], st.cfg[`CMDC_LL_SUM_BIT], st.cfg[`CMDC_RA_SUM_BIT]};
  assign common_electrode_drive_sum_o = st.cfg[`CMDC_CE_SUM_BIT];
  assign common_electrode_ref_enable_o = st.cfg[`CMDC_CE_REF_BIT];
  assign reference_electrode_enable_o = st.cfg[`CMDC_REF_EN_BIT];
  assign shield_drive_enable_o = st.cfg[`CMDC_SHIELD_BIT];

  AST_EXT_OPENS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st.cfg[`CMDC_EXT_SRC_BIT] |-> (cm_switch_o == 3'h0) && (cm_src_o == cmdc_pkg::CMDC_CM_EXTERNAL))
    else $error("external source left a switch closed");
  AST_REF_FALLBACK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!st.cfg[`CMDC_EXT_SRC_BIT] && st.cfg[23:21] == 3'h0) |-> cm_src_o == cmdc_pkg::CMDC_CM_INTERNAL_REF)
    else $error("internal reference not chosen");
  AST_CM_SELECT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !st.cfg[`CMDC_EXT_SRC_BIT] |-> cm_switch_o == st.cfg[23:21])
    else $error("common mode switch mismatch");
  AST_DRIVE_OUT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cm_drive_out_o == (st.cfg[`CMDC_DRIVE_OUT_BIT] && !st.cfg[`CMDC_EXT_SRC_BIT]))
    else $error("drive out wrong");
  AST_REF_RESERVED: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st.cfg[7:4] > 4'h3) |-> ref_electrode_o == 4'h0)
    else $error("reserved reference code selected an electrode");
  AST_RESET_VALUE: assert property (@(posedge mclk_i)
    !rst_n_i |=> st.cfg == `CMDC_REG_RESET)
    else $error("reset value wrong");
  AST_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st.cfg & ~`CMDC_WRITE_MASK) == 24'h000000)
    else $error("reserved bit set");
  sequence cmdc_full_write_s;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o &&
    s_axi_awaddr_i[11:2] == {2'h0, `CMDC_REG_INDEX} && s_axi_wstrb_i[2:0] == 3'h7;
  endsequence
  sequence cmdc_other_write_s;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o &&
    s_axi_awaddr_i[11:2] != {2'h0, `CMDC_REG_INDEX};
  endsequence
  sequence cmdc_read_take_s;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  AST_WRITE_TAKES: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_full_write_s |=> (st.cfg == ($past(s_axi_wdata_i[23:0]) & `CMDC_WRITE_MASK)) && s_axi_bvalid_o)
    else $error("write not stored");
  AST_SUM_LEVELS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    drive_sum_o == st.cfg[14:12] && common_electrode_drive_sum_o == st.cfg[9])
    else $error("summing outputs wrong");
  AST_WRITE_ANSWER: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o) |=> s_axi_bvalid_o)
    else $error("write response missing");
  AST_BVALID_STANDS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  AST_B_CLEARS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (s_axi_bvalid_o && s_axi_bready_i) |=> !s_axi_bvalid_o)
    else $error("write response not cleared");
  AST_BUSY_REFUSES: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  AST_READ_ANSWER: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_read_take_s |=> s_axi_rvalid_o)
    else $error("read response missing");
  AST_RVALID_STANDS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (s_axi_rvalid_o && !s_axi_rready_i) |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read response dropped early");
  AST_R_CLEARS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (s_axi_rvalid_o && s_axi_rready_i) |=> !s_axi_rvalid_o)
    else $error("read response not cleared");
  AST_READ_DATA: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_read_take_s ##0 (s_axi_araddr_i[11:2] == {2'h0, `CMDC_REG_INDEX}) |=>
    (s_axi_rdata_o == {8'h00, $past(st.cfg)}) && (s_axi_rresp_o == `CMDC_RESP_OKAY))
    else $error("read data differs from register");
  AST_UPPER_BYTE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_axi_rvalid_o |-> s_axi_rdata_o[31:24] == 8'h00)
    else $error("upper read byte not zero");
  AST_READ_UNMAPPED: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_read_take_s ##0 (s_axi_araddr_i[11:2] != {2'h0, `CMDC_REG_INDEX}) |=>
    (s_axi_rdata_o == 32'h00000000) && (s_axi_rresp_o == `CMDC_RESP_SLVERR))
    else $error("unmapped read not refused");
  AST_WRITE_UNMAPPED: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_other_write_s |=> $stable(st.cfg) && (s_axi_bresp_o == `CMDC_RESP_SLVERR))
    else $error("unmapped write not refused");
  AST_CFG_HOLDS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!s_axi_wvalid_i && !st.w_held) |=> $stable(st.cfg))
    else $error("register changed without a write");
  AST_LANE_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && !s_axi_wstrb_i[2]) |=>
    st.cfg[23:16] == $past(st.cfg[23:16]))
    else $error("unstrobed lane changed");
  AST_SEL_FROM_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_full_write_s ##0 !s_axi_wdata_i[`CMDC_EXT_SRC_BIT] |=> cm_switch_o == $past(s_axi_wdata_i[23:21]))
    else $error("written selects not applied");
  AST_SINGLE_SOURCE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!st.cfg[`CMDC_EXT_SRC_BIT] && st.cfg[23:21] != 3'h0) |-> cm_src_o == cmdc_pkg::CMDC_CM_ELECTRODES)
    else $error("electrode average not chosen");
  AST_EXT_FROM_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_full_write_s ##0 s_axi_wdata_i[`CMDC_EXT_SRC_BIT] |=>
    (cm_switch_o == 3'h0) && (cm_src_o == cmdc_pkg::CMDC_CM_EXTERNAL))
    else $error("written external source not applied");
  AST_DRIVE_FROM_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_full_write_s |=> cm_drive_out_o == ($past(s_axi_wdata_i[3]) && !$past(s_axi_wdata_i[2])))
    else $error("written drive out not applied");
  AST_SUM_FROM_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_full_write_s |=> drive_sum_o == $past(s_axi_wdata_i[14:12]))
    else $error("written summing bits not applied");
  AST_CE_SUM_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_full_write_s |=> common_electrode_drive_sum_o == $past(s_axi_wdata_i[9]))
    else $error("written common electrode sum not applied");
  AST_CE_REF_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_full_write_s |=> common_electrode_ref_enable_o == $past(s_axi_wdata_i[8]))
    else $error("written common electrode enable not applied");
  AST_RESET_OUTPUTS: assert property (@(posedge mclk_i)
    !rst_n_i |=> (drive_sum_o == 3'h0) && !common_electrode_ref_enable_o && !shield_drive_enable_o)
    else $error("outputs not cleared by reset");
  AST_REF_DECODE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st.cfg[7:4] < 4'h4) |-> ref_electrode_o == (4'h1 << st.cfg[7:4]))
    else $error("reference electrode decode wrong");
  AST_REF_EN_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_full_write_s |=> reference_electrode_enable_o == $past(s_axi_wdata_i[1]))
    else $error("written reference enable not applied");
  AST_SHIELD_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmdc_full_write_s |=> shield_drive_enable_o == $past(s_axi_wdata_i[0]))
    else $error("written shield enable not applied");
endmodule : cmdc_common_mode_drive_control

// *** logic/cmdc_switch_decode.sv ***
`timescale 1ns/1ps
`include "cmdc_consts.svh"
module cmdc_switch_decode (
  // Register image
  input  wire logic [23:0]         cfg_i,
  // Common mode switches
  output cmdc_pkg::cmdc_cm_src_t   cm_src_o,
  output logic [2:0]               cm_switch_o,
  output logic                     cm_drive_pin_o,
  // Reference drive electrode, one hot: driven lead, LA, LL, RA
  output logic [3:0]               ref_electrode_o
);
  logic [2:0] sel;
  assign sel = {cfg_i[`CMDC_LA_CM_BIT], cfg_i[`CMDC_LL_CM_BIT], cfg_i[`CMDC_RA_CM_BIT]};
  always_comb begin
    cm_src_o    = cmdc_pkg::CMDC_CM_ELECTRODES;
    cm_switch_o = 3'h0;
    if (cfg_i[`CMDC_EXT_SRC_BIT]) begin
      cm_src_o = cmdc_pkg::CMDC_CM_EXTERNAL;
    end else if (sel == 3'h0) begin
      cm_src_o = cmdc_pkg::CMDC_CM_INTERNAL_REF;
    end else begin
      cm_switch_o = sel;
    end
  end
  assign cm_drive_pin_o = cfg_i[`CMDC_DRIVE_OUT_BIT] & ~cfg_i[`CMDC_EXT_SRC_BIT];
  always_comb begin
    case (cfg_i[`CMDC_REFSEL_HI:`CMDC_REFSEL_LO])
      `CMDC_SEL_DRIVEN_LEAD: ref_electrode_o = 4'h1;
      `CMDC_SEL_LA:          ref_electrode_o = 4'h2;
      `CMDC_SEL_LL:          ref_electrode_o = 4'h4;
      `CMDC_SEL_RA:          ref_electrode_o = 4'h8;
      default:               ref_electrode_o = 4'h0;
    endcase
  end
endmodule : cmdc_switch_decode

// *** sim/common_mode_drive_control_tb_top.sv ***
`timescale 1ns/1ps
`include "cmdc_consts.svh"
module common_mode_drive_control_tb_top;
  logic                   mclk_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready;
  logic                   awready, wready, bvalid, arready, rvalid, drv, ce_sum, ce_ref, ref_en, shield;
  logic [11:0]            awaddr, araddr;
  logic [31:0]            wdata, rdata, seed, rd;
  logic [3:0]             wstrb, ref_el;
  logic [1:0]             bresp, rresp, rsp;
  logic [2:0]             cm_sw, dsum;
  logic [23:0]            m;
  cmdc_pkg::cmdc_cm_src_t cm_src;
  int                     num_errors, compares;

  cmdc_common_mode_drive_control dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .cm_src_o(cm_src), .cm_switch_o(cm_sw), .cm_drive_out_o(drv), .drive_sum_o(dsum),
    .common_electrode_drive_sum_o(ce_sum), .common_electrode_ref_enable_o(ce_ref),
    .ref_electrode_o(ref_el), .reference_electrode_enable_o(ref_en), .shield_drive_enable_o(shield));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  endfunction : xs

  task automatic wrap_up();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Each handshake is judged with the values that stand at the rising edge that takes it.
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ha, hw, hb;
    int   n;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk_i);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid & bready;
      r = bresp;
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) break;
    end
    bready <= 1'b0;
    if (n == 40) begin
      num_errors++;
      $display("[ERR] bvalid expected answer seen timeout");
      wrap_up();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hb;
    int   n;
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk_i);
      ha = arvalid & arready;
      hb = rvalid & rready;
      d = rdata;
      r = rresp;
      if (ha) arvalid <= 1'b0;
      if (hb) break;
    end
    rready <= 1'b0;
    if (n == 40) begin
      num_errors++;
      $display("[ERR] rvalid expected answer seen timeout");
      wrap_up();
    end
  endtask : axi_rd

  task automatic check_all();
    axi_rd(`CMDC_REG_ADDR, rd, rsp);
    chk("rdata", {8'h00, m}, rd);
    chk("rresp", `CMDC_RESP_OKAY, rsp);
    chk("cm_src", m[2] ? 32'd2 : (m[23:21] == 3'h0 ? 32'd1 : 32'd0), cm_src);
    chk("cm_switch", m[2] ? 3'h0 : m[23:21], cm_sw);
    chk("cm_drive", m[3] & ~m[2], drv);
    chk("drive_sum", m[14:12], dsum);
    chk("ce_sum", m[9], ce_sum);
    chk("ce_ref", m[8], ce_ref);
    chk("ref_el", m[7:4] < 4'h4 ? 4'h1 << m[7:4] : 4'h0, ref_el);
    chk("ref_en", m[1], ref_en);
    chk("shield", m[0], shield);
  endtask : check_all

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    axi_wr(a, d, s, rsp);
    chk("bresp", a == `CMDC_REG_ADDR ? `CMDC_RESP_OKAY : `CMDC_RESP_SLVERR, rsp);
    for (int l = 0; l < 3; l++) if (a == `CMDC_REG_ADDR && s[l]) m[l*8+:8] = d[l*8+:8];
    check_all();
  endtask : wr_chk

  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    m = `CMDC_REG_RESET;
  endtask : do_reset

  initial begin
    {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready, rst_n_i} = '0;
    num_errors = 0;
    compares = 0;
    seed = 32'd59927;
    do_reset();
    check_all();
    $display("test reset done");
    // Reserved bits are kept clear, as software must; lane strobes stay random.
    repeat (40) begin
      seed = xs(seed);
      wr_chk(`CMDC_REG_ADDR, seed & 32'h00e073ff, seed[30:27]);
    end
    $display("test random done");
    for (int i = 0; i < 16; i++) wr_chk(`CMDC_REG_ADDR, {8'h00, i[2:0], 13'h0000, i[3:0], i[3:2], 2'b11}, 4'h7);
    $display("test table done");
    wr_chk(12'h018, 32'h0000000f, 4'hf);
    axi_rd(12'h010, rd, rsp);
    chk("unmapped_rdata", 32'h0, rd);
    chk("unmapped_rresp", `CMDC_RESP_SLVERR, rsp);
    $display("test unmapped done");
    do_reset();
    check_all();
    $display("test rereset done");
    wrap_up();
  end

  initial begin
    repeat (50000) @(posedge mclk_i);
    num_errors++;
    $display("[ERR] run expected finish seen timeout");
    wrap_up();
  end
endmodule : common_mode_drive_control_tb_top
